//--- design/flash_pkg.sv
// Shared opcodes, status layout, frame lengths and array geometry.
package flash_pkg;

    // Command opcodes
    localparam logic [7:0] SET_WRITE_LATCH_CMD      = 8'h06;
    localparam logic [7:0] PAGE_WRITE_CMD           = 8'h02;
    localparam logic [7:0] QUAD_PAGE_WRITE_CMD      = 8'h32;
    localparam logic [7:0] SMALL_REGION_ERASE_CMD   = 8'h20;
    localparam logic [7:0] LARGE_REGION_ERASE_CMD   = 8'hd8;
    localparam logic [7:0] FULL_ARRAY_ERASE_CMD     = 8'hc7;
    localparam logic [7:0] STATUS_READ_CMD          = 8'h05;
    localparam logic [7:0] DUAL_IO_READ_CMD         = 8'hbb;
    localparam logic [7:0] QUAD_IO_READ_CMD         = 8'heb;
    localparam logic [7:0] CONTINUOUS_MODE_CLEAR_CMD = 8'hff;

    // Status byte bit positions
    localparam int STAT_WIP_POS = 0;
    localparam int STAT_WEL_POS = 1;
    localparam int STAT_BP_POS  = 2;
    localparam int STAT_QE_POS  = 6;

    // Frame lengths in serial clock edges
    localparam logic [15:0] OPCODE_EDGES    = 16'h0008;
    localparam logic [15:0] ERASE_EDGES     = 16'h0020;
    localparam logic [15:0] PROG_MIN_EDGES  = 16'h0028;
    localparam logic [15:0] QPROG_MIN_EDGES = 16'h0010;

    // Array geometry: byte address bits of page, sector and block
    localparam int PAGE_SHIFT   = 8;
    localparam int SECTOR_SHIFT = 12;
    localparam int BLOCK_SHIFT  = 16;
    localparam int PAGE_BYTES   = 256;

    // Reset values
    localparam logic [7:0] ERASED_BYTE  = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Execution states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PROG  = 3'b010,
        ST_ERASE = 3'b100
    } state_type;

endpackage : flash_pkg

//--- design/flash_program_erase.sv
// Serial flash command front end with page program and erase engine.
//
// Overview of operation
// - Mode reset clears continuous read mode bits
// - Page program writes one to 256 bytes
// - Program into protected page is ignored
// - Opcode, three address bytes, then data bytes
// - Program starts on chip select rise only
// - Busy device ignores all but status read
// - Progress bit is one while programming
// - Over 256 bytes wraps, last 256 kept
// - Column wraps to page start at end
// - Unaddressed page bytes keep old content
// - Programming only clears bits to zero
// - Quad program needs quad enable and latch
// - Quad program moves address, data on four lines
// - Uniform 4K sectors, sixteen per 64K block
// - Erase sets every bit of region to one
// - Sector erase clears only addressed sector
// - Block erase and chip erase also offered
// - Erase needs write latch, latch cleared after
// - Erase starts when chip select rises
// - Progress bit is one while erasing
// - Continuous read mode held until mode reset
// - Write enable command sets the write latch
`timescale 1ns/1ps
module flash_program_erase #(
    parameter int MEM_AW = 19
) (
    // System clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Serial link from the host
    input  wire logic              sck,
    input  wire logic              chip_select_n,
    input  wire logic              quad_line_0_in,
    output logic                   quad_line_0_out,
    output logic                   quad_line_0_oe,
    input  wire logic              quad_line_1_in,
    output logic                   quad_line_1_out,
    output logic                   quad_line_1_oe,
    input  wire logic              quad_line_2_in,
    output logic                   quad_line_2_out,
    output logic                   quad_line_2_oe,
    input  wire logic              quad_line_3_in,
    output logic                   quad_line_3_out,
    output logic                   quad_line_3_oe,
    // Configuration pins
    input  wire logic              protect_field_bit0,
    input  wire logic              protect_field_bit1,
    input  wire logic              protect_field_bit2,
    input  wire logic              protect_field_bit3,
    input  wire logic              quad_enable_bit,
    // Status
    output logic                   write_in_progress_bit,
    output logic                   write_enable_latch,
    output logic                   continuous_mode,
    // Array inspection port
    input  wire logic [MEM_AW-1:0] inspect_addr,
    output logic      [7:0]        inspect_data
);

    localparam int MEM_BYTES = 1 << MEM_AW;
    localparam int NUM_BLOCKS = MEM_BYTES >> flash_pkg::BLOCK_SHIFT;
    localparam logic [MEM_AW-1:0] SEC_MASK =
        MEM_AW'((1 << flash_pkg::SECTOR_SHIFT) - 1);
    localparam logic [MEM_AW-1:0] BLK_MASK =
        MEM_AW'((1 << flash_pkg::BLOCK_SHIFT) - 1);
    localparam logic [MEM_AW-1:0] ALL_MASK = '1;

    // True when the address falls in the top blocks locked by the field
    function automatic logic region_locked(input logic [MEM_AW-1:0] a,
                                           input logic [3:0]        bp);
        int unsigned blk;
        int unsigned nprot;
        blk = 32'(a) >> flash_pkg::BLOCK_SHIFT;
        if (bp == 4'h0) begin
            return 1'b0;
        end
        nprot = 32'd1 << (32'(bp) - 32'd1);
        if (nprot >= 32'(NUM_BLOCKS)) begin
            return 1'b1;
        end
        return blk >= (32'(NUM_BLOCKS) - nprot);
    endfunction : region_locked

    // ---------------- Link clock domain ----------------

    logic                        frame_start_ff;
    logic [15:0]                 edge_cnt_ff;
    logic [2:0]                  bit_pos_ff;
    logic [2:0]                  byte_num_ff;
    logic [7:0]                  shift_ff;
    logic [7:0]                  opcode_ff;
    logic                        quad_ff;
    logic [23:0]                 addr_ff;
    logic [7:0]                  col_ff;
    logic [7:0]                  page_buf_ff [flash_pkg::PAGE_BYTES];
    logic [flash_pkg::PAGE_BYTES-1:0] page_mask_ff;
    logic                        stat_act_ff;
    logic [7:0]                  stat_sr_ff;
    logic [7:0]                  stat_s1_ff;
    logic [7:0]                  stat_s2_ff;
    logic                        so_ff;
    logic                        so_oe_ff;
    logic [7:0]                  status_ff;

    // Chip select high marks the next edge as the first of a frame
    always_ff @(posedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            frame_start_ff <= 1'b1;
        end else begin
            frame_start_ff <= 1'b0;
        end
    end

    // Status crosses into the link domain through two sck flip-flops
    always_ff @(posedge sck) begin
        stat_s1_ff <= status_ff;
        stat_s2_ff <= stat_s1_ff;
    end

    // Bit and byte framing: one line during opcode, four after quad opcode
    wire       first     = frame_start_ff;
    wire       quad_now  = !first && quad_ff;
    wire [2:0] cur_pos   = first ? 3'h0 : bit_pos_ff;
    wire [3:0] pos_sum   = {1'b0, cur_pos} + (quad_now ? 4'h4 : 4'h1);
    wire       byte_done = pos_sum[3];
    wire [2:0] cur_bn    = first ? 3'h0 : byte_num_ff;
    wire [7:0] nxt_shift = quad_now ?
        {shift_ff[3:0], quad_line_3_in, quad_line_2_in,
         quad_line_1_in, quad_line_0_in} :
        {shift_ff[6:0], quad_line_0_in};
    wire       link_busy = stat_s2_ff[flash_pkg::STAT_WIP_POS];
    wire       take_data = byte_done && (cur_bn == 3'h4) && !link_busy;

    // Edge counter, bit position and byte number of the frame
    always_ff @(posedge sck) begin
        edge_cnt_ff <= first ? 16'h0001 :
                       (edge_cnt_ff == 16'hffff ? edge_cnt_ff :
                        edge_cnt_ff + 16'h0001);
        bit_pos_ff  <= pos_sum[2:0];
        byte_num_ff <= (byte_done && cur_bn != 3'h4) ?
                       cur_bn + 3'h1 : cur_bn;
        shift_ff    <= nxt_shift;
    end

    // Opcode, address and starting column in arrival order
    always_ff @(posedge sck) begin
        if (first) begin
            quad_ff <= 1'b0;
        end
        if (byte_done && cur_bn == 3'h0) begin
            opcode_ff <= nxt_shift;
            quad_ff   <= (nxt_shift == flash_pkg::QUAD_PAGE_WRITE_CMD);
        end
        if (byte_done && cur_bn >= 3'h1 && cur_bn <= 3'h3) begin
            addr_ff <= {addr_ff[15:0], nxt_shift};
        end
        if (byte_done && cur_bn == 3'h3) begin
            col_ff <= nxt_shift;
        end else if (take_data) begin
            col_ff <= col_ff + 8'h01;
        end
    end

    // Page buffer; data held still while the engine is busy, byte mask cleared at every frame start
    always_ff @(posedge sck) begin
        if (first) begin
            page_mask_ff <= '0;
        end else if (take_data) begin
            page_mask_ff[col_ff] <= 1'b1;
        end
        if (take_data) begin
            page_buf_ff[col_ff] <= nxt_shift;
        end
    end

    // Status read repeats the status byte for as long as clocks come
    always_ff @(posedge sck) begin
        if (first) begin
            stat_act_ff <= 1'b0;
        end else if (byte_done && cur_bn == 3'h0 &&
                     nxt_shift == flash_pkg::STATUS_READ_CMD) begin
            stat_act_ff <= 1'b1;
        end
        if (byte_done) begin
            stat_sr_ff <= stat_s2_ff;
        end else begin
            stat_sr_ff <= {stat_sr_ff[6:0], 1'b0};
        end
    end

    // Output data changes on the falling edge; released with chip select
    always_ff @(negedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end else begin
            so_ff    <= stat_sr_ff[7];
            so_oe_ff <= stat_act_ff;
        end
    end

    assign quad_line_1_out = so_ff;
    assign quad_line_1_oe  = so_oe_ff;

    // ---------------- System clock domain ----------------

    flash_pkg::state_type        state_ff;
    flash_pkg::state_type        nxt_state;
    logic                        cs_s1_ff;
    logic                        cs_s2_ff;
    logic                        cs_s3_ff;
    logic [3:0]                  bp_s1_ff;
    logic [3:0]                  bp_s2_ff;
    logic                        qe_s1_ff;
    logic                        qe_s2_ff;
    logic                        wel_ff;
    logic                        wip_ff;
    logic                        cont_ff;
    logic [MEM_AW-1:0]           walk_ff;
    logic [MEM_AW-1:0]           last_ff;
    logic [7:0]                  mem_ff [MEM_BYTES];
    logic [7:0]                  inspect_ff;
    logic                        idle_out_ff;

    // Pins pass two flip-flops before use
    always_ff @(posedge clk) begin
        cs_s1_ff <= chip_select_n;
        cs_s2_ff <= cs_s1_ff;
        cs_s3_ff <= cs_s2_ff;
        bp_s1_ff <= {protect_field_bit3, protect_field_bit2,
                     protect_field_bit1, protect_field_bit0};
        bp_s2_ff <= bp_s1_ff;
        qe_s1_ff <= quad_enable_bit;
        qe_s2_ff <= qe_s1_ff;
    end

    // Frame fields are static while chip select is high
    wire              frame_end = cs_s2_ff && !cs_s3_ff;
    wire              idle      = (state_ff == flash_pkg::ST_IDLE);
    wire              accept    = frame_end && idle;
    wire [MEM_AW-1:0] f_addr    = addr_ff[MEM_AW-1:0];
    wire              has_op    = edge_cnt_ff >= flash_pkg::OPCODE_EDGES;
    wire              whole_op  = edge_cnt_ff == flash_pkg::OPCODE_EDGES;
    wire              unlocked  = !region_locked(f_addr, bp_s2_ff);

    // Command decode; write enable, program and erase frames ending off a byte boundary are dropped
    wire is_set_write_latch_cmd = !cont_ff && whole_op &&
                   opcode_ff == flash_pkg::SET_WRITE_LATCH_CMD;
    wire is_mr   = has_op &&
                   opcode_ff == flash_pkg::CONTINUOUS_MODE_CLEAR_CMD;
    wire is_cont = !cont_ff && has_op &&
                   (opcode_ff == flash_pkg::DUAL_IO_READ_CMD ||
                    opcode_ff == flash_pkg::QUAD_IO_READ_CMD);
    wire is_pp   = !cont_ff && opcode_ff == flash_pkg::PAGE_WRITE_CMD &&
                   edge_cnt_ff >= flash_pkg::PROG_MIN_EDGES &&
                   edge_cnt_ff[2:0] == 3'h0;
    wire is_qpp  = !cont_ff && quad_ff && qe_s2_ff &&
                   edge_cnt_ff >= flash_pkg::QPROG_MIN_EDGES &&
                   !edge_cnt_ff[0];
    wire is_se   = !cont_ff && edge_cnt_ff == flash_pkg::ERASE_EDGES &&
                   opcode_ff == flash_pkg::SMALL_REGION_ERASE_CMD;
    wire is_be   = !cont_ff && edge_cnt_ff == flash_pkg::ERASE_EDGES &&
                   opcode_ff == flash_pkg::LARGE_REGION_ERASE_CMD;
    wire is_ce   = !cont_ff && whole_op &&
                   opcode_ff == flash_pkg::FULL_ARRAY_ERASE_CMD;

    // Region mask chosen by erase kind
    wire [MEM_AW-1:0] er_mask = is_se ? SEC_MASK :
                                (is_be ? BLK_MASK : ALL_MASK);
    wire ce_ok    = bp_s2_ff == 4'h0;
    wire go_prog  = accept && wel_ff && (is_pp || is_qpp) &&
                    unlocked;
    wire go_erase = accept && wel_ff &&
                    (((is_se || is_be) && unlocked) ||
                     (is_ce && ce_ok));
    wire walk_end = walk_ff == last_ff;

    // Engine state: program walks the page, erase walks the region
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            flash_pkg::ST_IDLE: begin
                if (go_prog) begin
                    nxt_state = flash_pkg::ST_PROG;
                end else if (go_erase) begin
                    nxt_state = flash_pkg::ST_ERASE;
                end
            end
            flash_pkg::ST_PROG, flash_pkg::ST_ERASE: begin
                if (walk_end) begin
                    nxt_state = flash_pkg::ST_IDLE;
                end
            end
            default: nxt_state = flash_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= flash_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Walk pointer: program covers the addressed page, erase the region
    always_ff @(posedge clk) begin
        if (rst) begin
            walk_ff <= '0;
            last_ff <= '0;
        end else if (go_prog) begin
            walk_ff <= {f_addr[MEM_AW-1:flash_pkg::PAGE_SHIFT], 8'h00};
            last_ff <= {f_addr[MEM_AW-1:flash_pkg::PAGE_SHIFT], 8'hff};
        end else if (go_erase) begin
            walk_ff <= f_addr & ~er_mask;
            last_ff <= f_addr | er_mask;
        end else if (!idle && !walk_end) begin
            walk_ff <= walk_ff + MEM_AW'(1);
        end
    end

    // Array write: program ANDs buffered bytes, erase writes all ones
    wire [7:0] walk_col  = walk_ff[7:0];
    wire       prog_hit  = (state_ff == flash_pkg::ST_PROG) &&
                           page_mask_ff[walk_col];
    wire       erase_hit = state_ff == flash_pkg::ST_ERASE;
    wire [7:0] prog_byte = mem_ff[walk_ff] &
                           page_buf_ff[walk_col];

    // Array contents are data, not control, so they have no reset
    always_ff @(posedge clk) begin
        if (prog_hit) begin
            mem_ff[walk_ff] <= prog_byte;
        end else if (erase_hit) begin
            mem_ff[walk_ff] <= flash_pkg::ERASED_BYTE;
        end
    end

    // Write latch: set by write enable, cleared when a cycle completes
    always_ff @(posedge clk) begin
        if (rst) begin
            wel_ff <= 1'b0;
        end else if (!idle && walk_end) begin
            wel_ff <= 1'b0;
        end else if (accept && is_set_write_latch_cmd) begin
            wel_ff <= 1'b1;
        end
    end

    // Progress bit tracks the engine from the cycle after the start
    always_ff @(posedge clk) begin
        if (rst) begin
            wip_ff <= 1'b0;
        end else begin
            wip_ff <= nxt_state != flash_pkg::ST_IDLE;
        end
    end

    // Continuous read mode held until the mode reset opcode
    always_ff @(posedge clk) begin
        if (rst) begin
            cont_ff <= 1'b0;
        end else if (accept && is_mr) begin
            cont_ff <= 1'b0;
        end else if (accept && is_cont) begin
            cont_ff <= 1'b1;
        end
    end

    // Status byte seen by the status read command
    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= flash_pkg::STATUS_RESET;
        end else begin
            status_ff <= '0;
            status_ff[flash_pkg::STAT_WIP_POS] <= wip_ff;
            status_ff[flash_pkg::STAT_WEL_POS] <= wel_ff;
            status_ff[flash_pkg::STAT_BP_POS +: 4] <= bp_s2_ff;
            status_ff[flash_pkg::STAT_QE_POS] <= qe_s2_ff;
        end
    end

    // Inspection read and constant idle drive of unused lines
    always_ff @(posedge clk) begin
        if (rst) begin
            inspect_ff  <= '0;
            idle_out_ff <= 1'b0;
        end else begin
            inspect_ff  <= mem_ff[inspect_addr];
            idle_out_ff <= 1'b0;
        end
    end

    assign quad_line_0_out       = idle_out_ff;
    assign quad_line_0_oe        = idle_out_ff;
    assign quad_line_2_out       = idle_out_ff;
    assign quad_line_2_oe        = idle_out_ff;
    assign quad_line_3_out       = idle_out_ff;
    assign quad_line_3_oe        = idle_out_ff;
    assign write_in_progress_bit = wip_ff;
    assign write_enable_latch    = wel_ff;
    assign continuous_mode       = cont_ff;
    assign inspect_data          = inspect_ff;

endmodule : flash_program_erase

//--- tb/flash_program_erase_chk.sv
// Port checker for the program and erase block.
`timescale 1ns/1ps
module flash_program_erase_chk #(
    parameter int MEM_AW = 19
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link pins
    input wire logic chip_select_n,
    input wire logic quad_line_0_oe,
    input wire logic quad_line_1_oe,
    input wire logic quad_line_2_oe,
    input wire logic quad_line_3_oe,
    // Status
    input wire logic write_in_progress_bit,
    input wire logic write_enable_latch,
    input wire logic continuous_mode
);
    localparam int MEM_BYTES = 2 ** MEM_AW;
    logic [31:0] run_ff;
    logic [31:0] nxt_run;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Length of the current busy run
    assign nxt_run = write_in_progress_bit ? run_ff + 32'h1 : 32'h0;
    always_ff @(posedge clk) begin
        run_ff <= rst ? 32'h0 : nxt_run;
    end

    AST_BUSY_LEN: assert property ($fell(write_in_progress_bit) |->
        run_ff inside {32'h100, 32'h1000, 32'h10000, MEM_BYTES})
        else $error("busy run length wrong");
    AST_BUSY_MAX: assert property (run_ff <= MEM_BYTES)
        else $error("busy run too long");
    AST_START_LATCH: assert property ($rose(write_in_progress_bit)
        |-> write_enable_latch) else $error("busy without latch");
    AST_START_CS: assert property ($rose(write_in_progress_bit) |->
        $past(chip_select_n, 2) && $past(chip_select_n, 3))
        else $error("busy not after select rise");
    AST_END_ORDER: assert property ($fell(write_enable_latch) |->
        $fell(write_in_progress_bit))
        else $error("busy outlives latch clear");
    AST_END_LATCH: assert property ($fell(write_in_progress_bit)
        |-> !write_enable_latch) else $error("latch left set");
    AST_BUSY_MODE: assert property (write_in_progress_bit |=>
        $stable(continuous_mode)) else $error("mode moved while busy");
    AST_LATCH_IDLE: assert property ($rose(write_enable_latch) |->
        !$past(write_in_progress_bit) && !$past(continuous_mode)
        && $past(chip_select_n)) else $error("latch set wrongly");
    AST_MODE_CS: assert property ($changed(continuous_mode) |->
        $past(chip_select_n) && $past(chip_select_n, 2))
        else $error("mode changed in frame");
    AST_OE_FRAME: assert property (quad_line_1_oe |-> !chip_select_n)
        else $error("status driven outside frame");
    AST_SPARE_OE: assert property (!(quad_line_0_oe || quad_line_2_oe
        || quad_line_3_oe)) else $error("spare line driven");

    // Main scenarios reached
    cover property ($fell(write_in_progress_bit));
    cover property ($fell(continuous_mode));
    cover property ($rose(quad_line_1_oe));
endmodule : flash_program_erase_chk

bind flash_program_erase flash_program_erase_chk #(.MEM_AW(MEM_AW)) chk_i (
    .clk(clk), .rst(rst), .chip_select_n(chip_select_n),
    .quad_line_0_oe(quad_line_0_oe), .quad_line_1_oe(quad_line_1_oe),
    .quad_line_2_oe(quad_line_2_oe), .quad_line_3_oe(quad_line_3_oe),
    .write_in_progress_bit(write_in_progress_bit),
    .write_enable_latch(write_enable_latch),
    .continuous_mode(continuous_mode));

//--- tb/spi_host_model.sv
// Host controller model driving the serial link.
`timescale 1ns/1ps
module spi_host_model (
    // Link outputs
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] io,
    // Data back from the device
    input  wire logic  so
);
    logic [7:0] bq[$];
    logic [7:0] rx;

    // Clock parked low between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'h5;
        rx = 8'h00;
    end

    // One link clock; data was set half a period before the rise
    task automatic pulse;
        #40 sck = 1'b1;
        rx = {rx[6:0], so};
        #40 sck = 1'b0;
    endtask : pulse

    // Queue sent under one select; idle lines toggle
    task automatic frame(input bit quad, input int extra);
        logic [7:0] b;
        cs_n = 1'b0;
        foreach (bq[i]) begin
            b = bq[i];
            for (int k = 0; k < ((quad && i > 0) ? 2 : 8); k++) begin
                if (quad && i > 0) begin
                    io = b[7:4];
                    b = b << 4;
                end else begin
                    io = {~io[3:1], b[7]};
                    b = b << 1;
                end
                pulse();
            end
        end
        for (int k = 0; k < extra; k++) begin
            io[0] = ~io[0];
            pulse();
        end
        #40 cs_n = 1'b1;
        io = ~io;
        #700;
    endtask : frame
endmodule : spi_host_model

//--- tb/tb.sv
// Self-checking bench for the program and erase block.
`timescale 1ns/1ps
module tb;
    localparam int MEM_AW = 16;
    logic              clk;
    logic              rst;
    logic [3:0]        prot;
    logic              quad_en;
    logic [MEM_AW-1:0] inspect_addr;
    logic [7:0]        inspect_data;
    logic              busy;
    logic              latch;
    logic              cmode;
    logic              sck;
    logic              cs_n;
    logic [3:0]        host_io;
    logic [3:0]        d_out;
    logic [3:0]        d_oe;
    wire  [3:0]        line = (d_oe & d_out) | (~d_oe & host_io);
    logic [7:0]        rd_ops[2] = '{flash_pkg::DUAL_IO_READ_CMD,
                                     flash_pkg::QUAD_IO_READ_CMD};
    int                num_errors;
    int                checks;

    flash_program_erase #(.MEM_AW(MEM_AW)) uut (
        .clk(clk), .rst(rst), .sck(sck), .chip_select_n(cs_n),
        .quad_line_0_in(line[0]), .quad_line_0_out(d_out[0]),
        .quad_line_0_oe(d_oe[0]), .quad_line_1_in(line[1]),
        .quad_line_1_out(d_out[1]), .quad_line_1_oe(d_oe[1]),
        .quad_line_2_in(line[2]), .quad_line_2_out(d_out[2]),
        .quad_line_2_oe(d_oe[2]), .quad_line_3_in(line[3]),
        .quad_line_3_out(d_out[3]), .quad_line_3_oe(d_oe[3]),
        .protect_field_bit0(prot[0]), .protect_field_bit1(prot[1]),
        .protect_field_bit2(prot[2]), .protect_field_bit3(prot[3]),
        .quad_enable_bit(quad_en), .write_in_progress_bit(busy),
        .write_enable_latch(latch), .continuous_mode(cmode),
        .inspect_addr(inspect_addr), .inspect_data(inspect_data));
    spi_host_model host (.sck(sck), .cs_n(cs_n), .io(host_io), .so(line[1]));

    // System clock, 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // Bytes past 256 are sent inverted
    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input int n, input logic [7:0] d, input int extra);
        host.bq = {op, a[23:16], a[15:8], a[7:0]};
        for (int i = 0; i < n; i++) host.bq.push_back(i < 256 ? d : ~d);
        host.frame(op == flash_pkg::QUAD_PAGE_WRITE_CMD, extra);
    endtask : send

    task automatic cmd(input logic [7:0] op);
        host.bq = {op};
        host.frame(1'b0, 0);
    endtask : cmd

    // Bounded wait for the end of a busy run
    task automatic settle;
        for (int n = 0; n < 70000 && busy === 1'b1; n++) @(posedge clk);
        check(busy, 1'b0);
    endtask : settle

    task automatic peek(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        inspect_addr <= a;
        repeat (2) @(posedge clk);
        #1 check(inspect_data, exp);
    endtask : peek

    // Pins need a few clocks to land
    task automatic pins(input logic [3:0] p, input logic q);
        @(posedge clk);
        prot <= p;
        quad_en <= q;
        repeat (4) @(posedge clk);
    endtask : pins

    task automatic latch_on;
        cmd(flash_pkg::SET_WRITE_LATCH_CMD);
        check(latch, 1'b1);
    endtask : latch_on

    initial begin
        rst = 1'b1;
        prot = 4'h0;
        quad_en = 1'b0;
        inspect_addr = '0;
        num_errors = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({busy, latch, cmode}, 3'h0);
        cmd(flash_pkg::CONTINUOUS_MODE_CLEAR_CMD);
        // Both read kinds hold the mode until cleared
        foreach (rd_ops[i]) begin
            send(rd_ops[i], 24'h0, 1, 8'ha5, 0);
            check(cmode, 1'b1);
            cmd(flash_pkg::SET_WRITE_LATCH_CMD);
            check(latch, 1'b0);
            cmd(flash_pkg::CONTINUOUS_MODE_CLEAR_CMD);
            check(cmode, 1'b0);
        end
        cmd(flash_pkg::FULL_ARRAY_ERASE_CMD);
        check(busy, 1'b0);
        latch_on();
        cmd(flash_pkg::FULL_ARRAY_ERASE_CMD);
        check(busy, 1'b1);
        host.bq = {flash_pkg::STATUS_READ_CMD, 8'h00};
        host.frame(1'b0, 0);
        check(host.rx, 8'h03);
        send(flash_pkg::PAGE_WRITE_CMD, 24'h0, 1, 8'h00, 0);
        settle();
        check(latch, 1'b0);
        peek(16'h0000, 8'hff);
        peek(16'h1234, 8'hff);
        // Three bytes from the last two columns wrap to column zero
        latch_on();
        send(flash_pkg::PAGE_WRITE_CMD, 24'h0000fe, 3, 8'ha5, 0);
        check(busy, 1'b1);
        settle();
        peek(16'h00fe, 8'ha5);
        peek(16'h0000, 8'ha5);
        peek(16'h0001, 8'hff);
        peek(16'h00fd, 8'hff);
        latch_on();
        send(flash_pkg::PAGE_WRITE_CMD, 24'h0000fe, 1, 8'h5a, 0);
        settle();
        peek(16'h00fe, 8'h00);
        // Two bytes beyond a page overwrite the first two columns
        latch_on();
        send(flash_pkg::PAGE_WRITE_CMD, 24'h000100, 258, 8'hee, 0);
        settle();
        peek(16'h0100, 8'h11);
        peek(16'h0102, 8'hee);
        latch_on();
        send(flash_pkg::PAGE_WRITE_CMD, 24'h000300, 1, 8'h00, 3);
        check(busy, 1'b0);
        pins(4'h1, 1'b0);
        send(flash_pkg::PAGE_WRITE_CMD, 24'h000300, 1, 8'h00, 0);
        check(busy, 1'b0);
        send(flash_pkg::LARGE_REGION_ERASE_CMD, 24'h000000, 0, 8'h00, 0);
        check(busy, 1'b0);
        pins(4'h0, 1'b0);
        peek(16'h0300, 8'hff);
        send(flash_pkg::QUAD_PAGE_WRITE_CMD, 24'h001200, 1, 8'hc3, 0);
        check(busy, 1'b0);
        pins(4'h0, 1'b1);
        send(flash_pkg::QUAD_PAGE_WRITE_CMD, 24'h001200, 1, 8'hc3, 0);
        check(busy, 1'b1);
        settle();
        peek(16'h1200, 8'hc3);
        // Inner address still clears the whole first sector only
        latch_on();
        send(flash_pkg::SMALL_REGION_ERASE_CMD, 24'h000fab, 0, 8'h00, 0);
        check(busy, 1'b1);
        settle();
        check(latch, 1'b0);
        peek(16'h00fe, 8'hff);
        peek(16'h0100, 8'hff);
        peek(16'h1200, 8'hc3);
        end_of_test();
    end

    // Watchdog beyond the longest run
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : tb
